/* File: bench/gp_timer_time_base_test.sv */
// Self-checking testbench of the up-counting timer time base.
module gp_timer_time_base_test
    import gp_timer_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic              clock;
    logic              rst_n;
    logic [ADDR_W-1:0] regAddr;
    logic [15:0]       regWrData;
    logic [15:0]       regRdData;
    logic              regWrite;
    logic              regRead;
    logic              slaveUpdateReq;
    logic              otherEventIrq;
    logic              debugHalt;
    logic [CHAN_N-1:0] channelOut;
    logic [CHAN_N-1:0] peripheralOut;
    logic [CHAN_N-1:0] portAPin;
    logic [CHAN_N-1:0] portBPin;
    logic [CHAN_N-1:0] portADrive;
    logic [CHAN_N-1:0] portBDrive;
    logic              irq;
    logic              updateEventOut;
    logic              counter_run_signal;
    logic              extMode;
    logic              extClk;
    logic              extMask;
    logic              rdSeen;
    logic [15:0]       expQ[$];
    int                err_total;
    int                check_count;
    int                uevCount;

    gp_timer_time_base gp_timer_time_base_inst (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .slaveUpdateReq(slaveUpdateReq),
        .externalClockMode(extMode), .external_clock_input(extClk),
        .clock_mask_input(extMask), .otherEventIrq(otherEventIrq),
        .debugHalt(debugHalt), .channelOut(channelOut),
        .peripheralOut(peripheralOut), .portAPin(portAPin),
        .portBPin(portBPin), .portADrive(portADrive),
        .portBDrive(portBDrive), .irq(irq),
        .updateEventOut(updateEventOut),
        .counter_run_signal(counter_run_signal)
    );

    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    task automatic print_verdict();
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clock);
        regWrite  <= 1'h1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite  <= 1'h0;
    endtask

    // The expected value is queued here and compared by the read monitor.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        @(posedge clock);
        expQ.push_back(e);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic slavePulse();
        @(posedge clock);
        slaveUpdateReq <= 1'h1;
        @(posedge clock);
        slaveUpdateReq <= 1'h0;
    endtask

    // Counts edges up to and including the next update pulse, bounded.
    task automatic waitUev(output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (updateEventOut !== 1'h1 && n < 300);
        if (n >= 300)
        begin
            err_total++;
            $display("BAD %0t no update pulse", $time);
            print_verdict();
        end
    endtask

    always @(posedge clock)
    begin
        if (rdSeen)
            check(regRdData, expQ.pop_front());
        rdSeen <= regRead;
        if (updateEventOut === 1'h1)
            uevCount++;
    end

    initial
    begin
        int n;
        int u0;
        logic [15:0] v;
        logic [3:0] act;
        logic [3:0] rm;
        rst_n = 1'h0;
        regAddr = '0;
        regWrData = 16'h0000;
        regWrite = 1'h0;
        regRead = 1'h0;
        slaveUpdateReq = 1'h0;
        otherEventIrq = 1'h0;
        debugHalt = 1'h0;
        channelOut = 4'h0;
        peripheralOut = 4'h0;
        extMode = 1'h0;
        extClk = 1'h0;
        extMask = 1'h0;
        rdSeen = 1'h0;
        err_total = 0;
        check_count = 0;
        uevCount = 0;
        v = 16'($urandom(33));
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        idle(3);
        rd(ADDR_RELOAD, RESET_RELOAD);
        rd(ADDR_COUNT, RESET_COUNT);
        rd(ADDR_CONTROL, ZERO16);
        wr(4'hC, 16'hFFFF);
        rd(4'hC, ZERO16);
        for (int i = 0; i < 4; i++)
        begin
            v = 16'($urandom());
            wr(ADDR_COUNT, v);
            rd(ADDR_COUNT, v);
            wr(ADDR_RELOAD, v);
            rd(ADDR_RELOAD, v);
            wr(ADDR_PRESCALE, v);
            rd(ADDR_PRESCALE, {12'h000, v[3:0]});
        end
        wr(ADDR_PRESCALE, ZERO16);
        wr(ADDR_COUNT, 16'h0005);
        u0 = uevCount;
        wr(ADDR_EVENT_GEN, ONE16);
        idle(3);
        check(16'(uevCount - u0), ONE16);
        rd(ADDR_COUNT, ZERO16);
        rd(ADDR_EVENT_GEN, ZERO16);
        idle(5);
        rd(ADDR_FLAG, ONE16);
        check({15'h0000, irq}, ONE16);
        wr(ADDR_FLAG, ONE16);
        idle(1);
        check({15'h0000, irq}, ZERO16);
        otherEventIrq <= 1'h1;
        idle(1);
        check({15'h0000, irq}, ONE16);
        otherEventIrq <= 1'h0;
        wr(ADDR_CONTROL, 16'h0004);
        u0 = uevCount;
        wr(ADDR_EVENT_GEN, ONE16);
        idle(3);
        check(16'(uevCount - u0), ONE16);
        rd(ADDR_FLAG, ZERO16);
        slavePulse();
        idle(2);
        rd(ADDR_FLAG, ONE16);
        wr(ADDR_FLAG, ONE16);
        wr(ADDR_COUNT, 16'h0005);
        wr(ADDR_CONTROL, 16'h0002);
        u0 = uevCount;
        wr(ADDR_EVENT_GEN, ONE16);
        slavePulse();
        idle(3);
        check(16'(uevCount - u0), ZERO16);
        rd(ADDR_COUNT, 16'h0005);
        rd(ADDR_FLAG, ZERO16);
        wr(ADDR_CONTROL, ZERO16);
        wr(ADDR_RELOAD, 16'h0003);
        wr(ADDR_EVENT_GEN, ONE16);
        debugHalt <= 1'h1;
        wr(ADDR_CONTROL, ONE16);
        #1 check({15'h0000, counter_run_signal}, ZERO16);
        @(posedge clock);
        #1 check({15'h0000, counter_run_signal}, ONE16);
        waitUev(n);
        waitUev(n);
        check(16'(n), 16'h0004);
        rd(ADDR_FLAG, ONE16);
        waitUev(n);
        wr(ADDR_PRESCALE, 16'h0002);
        waitUev(n);
        check({15'h0000, n <= 4}, ONE16);
        waitUev(n);
        waitUev(n);
        check(16'(n), 16'h0010);
        wr(ADDR_PRESCALE, ZERO16);
        wr(ADDR_RELOAD, 16'h0007);
        waitUev(n);
        waitUev(n);
        waitUev(n);
        check(16'(n), 16'h0008);
        wr(ADDR_CONTROL, 16'h0081);
        waitUev(n);
        wr(ADDR_RELOAD, ONE16);
        waitUev(n);
        check({15'h0000, n >= 4}, ONE16);
        waitUev(n);
        check(16'(n), 16'h0002);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clock);
            v = 16'($urandom());
            rm = 4'($urandom());
            act = v[3:0] & v[7:4];
            channelOut <= 4'($urandom());
            peripheralOut <= 4'($urandom());
            wr(ADDR_CHANNEL, {8'h00, v[7:0]});
            wr(ADDR_OPTION, {12'h000, rm});
            #1 check({12'h000, portADrive}, {12'h000, ~rm});
            check({12'h000, portBDrive}, {12'h000, rm});
            check({12'h000, portAPin & act & ~rm},
                  {12'h000, channelOut & act & ~rm});
            check({12'h000, portBPin & act & rm},
                  {12'h000, channelOut & act & rm});
            check({12'h000, portAPin & ~act},
                  {12'h000, peripheralOut & ~act});
        end
        wr(ADDR_CONTROL, ZERO16);
        wr(ADDR_RELOAD, 16'hFFFF);
        wr(ADDR_EVENT_GEN, ONE16);
        extMode <= 1'h1;
        wr(ADDR_CONTROL, ONE16);
        // Five clean rising edges count; the sixth arrives masked.
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clock);
            extClk  <= 1'h1;
            extMask <= 1'(i == 5);
            @(posedge clock);
            extClk  <= 1'h0;
            extMask <= 1'h0;
        end
        rd(ADDR_COUNT, 16'h0005);
        extMode <= 1'h0;
        idle(3);
        print_verdict();
    end
endmodule

/* File: src/gp_timer_pkg.sv */
// Package with register map, field positions and reset values of the timer.
package gp_timer_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_GEN = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_FLAG      = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_COUNT     = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_RELOAD    = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL   = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_OPTION    = 4'h7;
    localparam int CTL_EN   = 0;
    localparam int CTL_UDIS = 1;
    localparam int CTL_URS  = 2;
    localparam int CTL_ARBE = 7;
    localparam int EGR_UG   = 0;
    localparam int FLG_UIF  = 0;
    localparam int CHAN_N   = 4;
    localparam int CHAN_OUT_LSB = 0;
    localparam int CHAN_EN_LSB  = 4;
    localparam int EXP_W    = 4;
    localparam logic [15:0] RESET_COUNT  = 16'h0000;
    localparam logic [15:0] RESET_RELOAD = 16'hFFFF;
    localparam logic [15:0] ZERO16       = 16'h0000;
    localparam logic [15:0] ONE16        = 16'h0001;
endpackage

/* File: src/gp_timer_time_base.sv */
// Up-counting time base of a general-purpose timer with register port.
// How it works
// - A 16-bit counter with auto-reload value, fed through the prescaler.
// - Prescaler is a 16-bit counter dividing by two to a 4-bit power.
// - A new prescale exponent waits in a buffer until the next update.
// - Counter, reload and prescale read and write at any time.
// - Reload buffer goes to shadow at once, or per update when buffered.
// - Overflow makes an update unless disabled; software may force one.
// - Counter advances only on prescaler ticks while enable bit set.
// - Internal run signal follows the enable bit one cycle later.
// - Counting ignores core debug halt.
// - Up count from 0 to reload value, then wrap to 0 with overflow.
// - Update also from update-generate bit or slave request input.
// - Update-disable blocks all updates and freezes the prescaler shadow, and the reload shadow when buffered.
// - Software update restarts counter and prescaler, loading the buffered ratio.
// - With request-source set, software update leaves the flag clear.
// - Update sets flag, loads prescaler and reload shadows.
// - Interrupt request raised from update flag and other event inputs.
// - Timer drives a pin when its channel is output and enabled.
// - Per-channel remap bit routes channel to port A or port B pin.
// - External clock and mask inputs act only in external clock mode.
// - Each timer instance stands alone and shares no resources.
module gp_timer_time_base
    import gp_timer_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [15:0]       regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [15:0]       regRdData,
    input  wire logic              slaveUpdateReq,
    input  wire logic              externalClockMode,
    input  wire logic              external_clock_input,
    input  wire logic              clock_mask_input,
    input  wire logic              otherEventIrq,
    input  wire logic              debugHalt,
    input  wire logic [CHAN_N-1:0] channelOut,
    input  wire logic [CHAN_N-1:0] peripheralOut,
    output logic      [CHAN_N-1:0] portAPin,
    output logic      [CHAN_N-1:0] portBPin,
    output logic      [CHAN_N-1:0] portADrive,
    output logic      [CHAN_N-1:0] portBDrive,
    output logic                   irq,
    output logic                   updateEventOut,
    output logic                   counter_run_signal
);
    logic        rstMeta_r;
    logic        rstSync_r;
    logic [7:0]  control_reg_one_r;
    logic [15:0] count_value_reg_r;
    logic [EXP_W-1:0] prescale_exponent_r;
    logic [EXP_W-1:0] prescaleShadow_r;
    logic [15:0] prescaleCount_r;
    logic [15:0] reload_value_reg_r;
    logic [15:0] reloadShadow_r;
    logic        update_flag_r;
    logic [7:0]  channel_mode_reg_r;
    logic [CHAN_N-1:0] channel_pin_remap_r;
    logic        run_r;
    logic        extPrev_r;
    logic        counter_tick_clock;
    logic        swUpdate;
    logic        overflow;
    logic        update_event;
    logic [15:0] reloadActive;
    logic        sourceTick;
    logic [15:0] rdData_nxt;
    logic [15:0] rdData_r;
    logic        flagSet;
    logic [CHAN_N-1:0] ownMask;

    function automatic logic wrHit(input logic [ADDR_W-1:0] a);
        return regWrite && (regAddr == a);
    endfunction

    // Reset is released through two flops so deassertion is clean.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            control_reg_one_r <= 8'h00;
        else if (wrHit(ADDR_CONTROL))
            control_reg_one_r <= regWrData[7:0];
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            run_r <= 1'b0;
        else
            run_r <= control_reg_one_r[CTL_EN];
    end
    assign counter_run_signal = run_r;

    // Debug halt is deliberately not used: the timer keeps counting.

    // External edge detection only matters in external clock mode.
    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            extPrev_r <= 1'b0;
        else
            extPrev_r <= external_clock_input;
    end
    assign sourceTick = externalClockMode
        ? (external_clock_input && !extPrev_r && !clock_mask_input)
        : 1'b1;

    assign swUpdate = wrHit(ADDR_EVENT_GEN) && regWrData[EGR_UG];
    assign reloadActive = control_reg_one_r[CTL_ARBE]
        ? reloadShadow_r : reload_value_reg_r;

    // Prescaler ticks when its count reaches 2^exp - 1.
    assign counter_tick_clock = run_r && sourceTick
        && (prescaleCount_r == ((ONE16 << prescaleShadow_r) - ONE16));
    assign overflow = counter_tick_clock
        && (count_value_reg_r >= reloadActive);
    assign update_event = !control_reg_one_r[CTL_UDIS]
        && (overflow || swUpdate || slaveUpdateReq);
    assign updateEventOut = update_event;

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            prescaleCount_r <= ZERO16;
        else if (update_event && !overflow)
            prescaleCount_r <= ZERO16;
        else if (counter_tick_clock)
            prescaleCount_r <= ZERO16;
        else if (run_r && sourceTick)
            prescaleCount_r <= prescaleCount_r + ONE16;
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            count_value_reg_r <= RESET_COUNT;
        else if (update_event && !overflow)
            count_value_reg_r <= ZERO16;
        else if (wrHit(ADDR_COUNT))
            count_value_reg_r <= regWrData;
        else if (overflow)
            count_value_reg_r <= ZERO16;
        else if (counter_tick_clock)
            count_value_reg_r <= count_value_reg_r + ONE16;
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            prescale_exponent_r <= '0;
        else if (wrHit(ADDR_PRESCALE))
            prescale_exponent_r <= regWrData[EXP_W-1:0];
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            prescaleShadow_r <= '0;
        else if (update_event)
            prescaleShadow_r <= prescale_exponent_r;
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            reload_value_reg_r <= RESET_RELOAD;
        else if (wrHit(ADDR_RELOAD))
            reload_value_reg_r <= regWrData;
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            reloadShadow_r <= RESET_RELOAD;
        else if (update_event || !control_reg_one_r[CTL_ARBE])
            reloadShadow_r <= reload_value_reg_r;
    end

    // A software update under request-source select stays silent, but an
    // overflow or a slave request in the same cycle still raises the flag.
    assign flagSet = update_event
        && (overflow || slaveUpdateReq || !control_reg_one_r[CTL_URS]);

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            update_flag_r <= 1'b0;
        else if (flagSet)
            update_flag_r <= 1'b1;
        else if (wrHit(ADDR_FLAG) && regWrData[FLG_UIF])
            update_flag_r <= 1'b0;
    end
    assign irq = update_flag_r || otherEventIrq;

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            channel_mode_reg_r <= 8'h00;
        else if (wrHit(ADDR_CHANNEL))
            channel_mode_reg_r <= regWrData[7:0];
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            channel_pin_remap_r <= '0;
        else if (wrHit(ADDR_OPTION))
            channel_pin_remap_r <= regWrData[CHAN_N-1:0];
    end

    assign ownMask = channel_mode_reg_r[CHAN_OUT_LSB +: CHAN_N]
        & channel_mode_reg_r[CHAN_EN_LSB +: CHAN_N];

    // Each instance owns all its state, so two timers share nothing.
    always_comb
    begin
        for (int i = 0; i < CHAN_N; i++)
        begin
            logic timerOwns;
            timerOwns = channel_mode_reg_r[CHAN_OUT_LSB + i]
                && channel_mode_reg_r[CHAN_EN_LSB + i];
            portAPin[i]   = timerOwns ? channelOut[i]
                                      : peripheralOut[i];
            portBPin[i]   = portAPin[i];
            portADrive[i] = !channel_pin_remap_r[i];
            portBDrive[i] = channel_pin_remap_r[i];
        end
    end

    always_comb
    begin
        unique case (regAddr)
            ADDR_CONTROL:  rdData_nxt = {8'h00, control_reg_one_r};
            ADDR_FLAG:     rdData_nxt = {15'h0000, update_flag_r};
            ADDR_COUNT:    rdData_nxt = count_value_reg_r;
            ADDR_PRESCALE: rdData_nxt = {12'h000, prescale_exponent_r};
            ADDR_RELOAD:   rdData_nxt = reload_value_reg_r;
            ADDR_CHANNEL:  rdData_nxt = {8'h00, channel_mode_reg_r};
            ADDR_OPTION:   rdData_nxt = {12'h000, channel_pin_remap_r};
            default:       rdData_nxt = ZERO16;
        endcase
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
            rdData_r <= ZERO16;
        else if (regRead)
            rdData_r <= rdData_nxt;
        else
            rdData_r <= ZERO16;
    end
    assign regRdData = rdData_r;

    // All checks below run on the one clock and wait for the synced reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstSync_r);

    // Steps of the counting path, all but s_plain_tick shared by two properties.
    sequence s_top_tick;
        counter_tick_clock && (count_value_reg_r >= reloadActive);
    endsequence

    sequence s_plain_tick;
        counter_tick_clock && !overflow && !update_event
            && !wrHit(ADDR_COUNT);
    endsequence

    sequence s_sw_update;
        swUpdate && !control_reg_one_r[CTL_UDIS];
    endsequence

    sequence s_count_zero;
        count_value_reg_r == ZERO16;
    endsequence

    a_run_latency: assert property (
        $rose(control_reg_one_r[CTL_EN]) |-> !run_r ##1 run_r)
        else $error("run signal latency wrong");

    a_wrap_zero: assert property (
        s_top_tick ##0 (!swUpdate && !wrHit(ADDR_COUNT)) |=> s_count_zero)
        else $error("counter did not wrap");

    a_top_update: assert property (
        s_top_tick |-> update_event || control_reg_one_r[CTL_UDIS])
        else $error("overflow without update");

    a_udis_block: assert property (
        control_reg_one_r[CTL_UDIS] |-> !update_event)
        else $error("update while disabled");

    a_shadow_frozen: assert property (
        control_reg_one_r[CTL_UDIS] && control_reg_one_r[CTL_ARBE]
        |=> $stable(reloadShadow_r) && $stable(prescaleShadow_r))
        else $error("shadow moved while updates disabled");

    a_sw_restart: assert property (
        s_sw_update |=> s_count_zero ##0 (prescaleCount_r == ZERO16))
        else $error("software update did not restart");

    a_urs_quiet: assert property (
        swUpdate && control_reg_one_r[CTL_URS] && !update_flag_r
        && !overflow && !slaveUpdateReq |=> !update_flag_r)
        else $error("flag set despite source select");

    a_ug_flag: assert property (
        s_sw_update ##0 !control_reg_one_r[CTL_URS] |=> update_flag_r)
        else $error("software update left flag clear");

    a_slave_flag: assert property (
        slaveUpdateReq && !control_reg_one_r[CTL_UDIS] |=> update_flag_r)
        else $error("slave update left flag clear");

    a_psc_load: assert property (
        update_event |=> prescaleShadow_r == $past(prescale_exponent_r))
        else $error("prescaler shadow not loaded");

    a_psc_hold: assert property (
        !update_event |=> $stable(prescaleShadow_r))
        else $error("prescaler ratio changed between updates");

    a_reload_load: assert property (
        update_event && control_reg_one_r[CTL_ARBE]
        |=> reloadShadow_r == $past(reload_value_reg_r))
        else $error("reload shadow not loaded on update");

    a_flag_hold: assert property (
        update_flag_r && !(wrHit(ADDR_FLAG) && regWrData[FLG_UIF])
        |=> update_flag_r)
        else $error("flag dropped without clear");

    a_no_tick_idle: assert property (
        !run_r && !update_event && !wrHit(ADDR_COUNT)
        |=> $stable(count_value_reg_r))
        else $error("counter moved while stopped");

    a_tick_step: assert property (
        s_plain_tick
        |=> count_value_reg_r == $past(count_value_reg_r) + ONE16)
        else $error("counter did not step on tick");

    a_arr_direct: assert property (
        !control_reg_one_r[CTL_ARBE]
        |=> reloadShadow_r == $past(reload_value_reg_r))
        else $error("reload shadow not transparent");

    a_ext_gate: assert property (
        externalClockMode
        && (clock_mask_input || !(external_clock_input && !extPrev_r))
        |-> !counter_tick_clock)
        else $error("tick without external edge");

    a_read_count: assert property (
        regRead && (regAddr == ADDR_COUNT)
        |=> regRdData == $past(count_value_reg_r))
        else $error("count read back wrong");

    a_read_idle: assert property (
        !regRead |=> regRdData == ZERO16)
        else $error("read data outside read cycle");

    a_pin_owner: assert property (
        portAPin == ((ownMask & channelOut) | (~ownMask & peripheralOut)))
        else $error("pin not driven by its owner");

    a_remap_drive: assert property (
        portBDrive == channel_pin_remap_r
        && portADrive == ~channel_pin_remap_r)
        else $error("drive enable does not follow remap");
endmodule
